// *** tb/sar_checker.sv ***
// link assertions between the device and host ends
`timescale 1ns/1ns
module sar_checker (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    input wire logic so,
    input wire logic so_oe,
    input wire logic so_line
);
    // ------------------------------------------------------------
    // frame tracking: rising serial edges and the opcode they carry
    // ------------------------------------------------------------
    logic sck_q;
    logic [15:0] rise_q;
    logic [7:0] op_q;
    always_ff @(posedge i_clk)
    begin
        sck_q <= i_sys_rst ? 1'b0 : sck;
    end
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst || cs_n)
            rise_q <= 16'h0000;
        else if (sck && !sck_q)
            rise_q <= rise_q + 16'h0001;
    end
    // opcode kept after deselect so the frame end can still be judged
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
            op_q <= 8'h00;
        else if (!cs_n && sck && !sck_q && rise_q < 16'h0008)
            op_q <= {op_q[6:0], si};
    end
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    a_oe_off_desel: assert property (cs_n |-> !so_oe)
        else $error("data output enabled while deselected");
    a_line_idle_high: assert property (cs_n |-> so_line)
        else $error("data line not released while deselected");
    a_sck_idle_low: assert property (cs_n |-> !sck)
        else $error("serial clock not low outside a frame");
    a_so_on_fall: assert property ((so_oe && $past(so_oe) && $changed(so)) |-> $fell(sck))
        else $error("data output changed away from a falling edge");
    a_si_stable_high: assert property ((!cs_n && sck) |-> $stable(si))
        else $error("host data moved while clock high");
    a_read_after_dummy: assert property ((so_oe && op_q == sar_pkg::OP_SEC_READ)
        |-> rise_q >= 16'h0028)
        else $error("read data driven before address and dummies");
    a_oe_holds_frame: assert property ((so_oe && !cs_n) |=> (so_oe || cs_n))
        else $error("data output dropped inside a frame");
    a_high_phase: assert property ($rose(sck) |-> sck [*8] ##1 !sck)
        else $error("serial clock high phase wrong length");
    a_frame_whole: assert property (($rose(cs_n) && op_q == sar_pkg::OP_SEC_READ)
        |-> (rise_q >= 16'h0028 && rise_q[2:0] == 3'h0))
        else $error("read frame not whole bytes after header");
    a_cs_gap: assert property ($rose(cs_n) |-> cs_n [*8])
        else $error("deselect gap too short");
endmodule // sar_checker

// *** tb/sar_test.sv ***
// self-checking bench: host and device ends joined over the link
`timescale 1ns/1ns
module sar_test;
    logic i_clk = 1'b0;
    logic i_sys_rst = 1'b0;
    logic busy = 1'b0;
    logic mem_we = 1'b0;
    logic [9:0] mem_addr = 10'h000;
    logic [7:0] mem_wdata = 8'h00;
    logic vol_we = 1'b0;
    logic cmd_valid = 1'b0;
    logic [7:0] cmd_op = 8'h00;
    logic [23:0] cmd_addr = 24'h000000;
    logic cmd_hdr = 1'b0;
    logic [10:0] cmd_len = 11'h000;
    logic cmd_ready, rd_valid, done, abort, rst_busy;
    logic [7:0] rd_data, status1, rparam, cmode;
    logic [2:0] wrap;
    logic [7:0] rx_q[$];
    int num_errors = 0;
    int total_checks = 0;
    int n_abort = 0;
    int n_rbusy = 0;
    int cycles = 0;
    // ------------------------------------------------------------
    // ends, link and checker
    // ------------------------------------------------------------
    sar_link_if sar_link_if_inst();
    sar_dev sar_dev_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .link(sar_link_if_inst),
        .i_busy(busy), .i_mem_we(mem_we), .i_mem_addr(mem_addr), .i_mem_wdata(mem_wdata),
        .i_vol_we(vol_we), .i_vol_status(8'hfc), .i_vol_write_enable_latch(1'b1),
        .i_vol_param(8'h5a), .i_vol_mode(8'ha5), .i_vol_wrap(3'h5),
        .o_status1(status1), .o_read_param(rparam),
        .o_cont_mode(cmode), .o_wrap(wrap), .o_abort(abort), .o_rst_busy(rst_busy));
    sar_host sar_host_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .link(sar_link_if_inst),
        .i_cmd_valid(cmd_valid), .i_cmd_op(cmd_op), .i_cmd_addr(cmd_addr),
        .i_cmd_addr_en(cmd_hdr), .i_cmd_dummy_en(cmd_hdr), .i_cmd_rd_len(cmd_len),
        .o_cmd_ready(cmd_ready), .o_rd_valid(rd_valid), .o_rd_data(rd_data), .o_done(done));
    sar_checker sar_checker_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
        .cs_n(sar_link_if_inst.cs_n), .sck(sar_link_if_inst.sck), .si(sar_link_if_inst.si),
        .so(sar_link_if_inst.so), .so_oe(sar_link_if_inst.so_oe),
        .so_line(sar_link_if_inst.so_line));
    // ------------------------------------------------------------
    // clock, timeout and monitors
    // ------------------------------------------------------------
    always #4 i_clk = ~i_clk;
    // three reset windows of 3750 cycles dominate the run
    always @(posedge i_clk)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            num_errors++;
            test_done();
        end
    end
    always @(negedge i_clk)
    begin
        if (rd_valid === 1'b1)
            rx_q.push_back(rd_data);
        if (abort === 1'b1)
            n_abort++;
        if (rst_busy === 1'b1)
            n_rbusy++;
    end
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic test_done();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_n(input string what, input int exp, input int got);
        total_checks++;
        if (got != exp)
        begin
            num_errors++;
            $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    function automatic logic [7:0] pat(input logic [9:0] a);
        return a[7:0] ^ {a[9:8], 6'h15};
    endfunction
    // one framed command; waits for the frame to close
    task automatic cmd(input logic [7:0] op, input logic [23:0] addr, input logic [10:0] len);
        while (cmd_ready !== 1'b1)
            @(negedge i_clk);
        @(posedge i_clk);
        cmd_valid <= 1'b1;
        cmd_op <= op;
        cmd_addr <= addr;
        cmd_hdr <= (op == sar_pkg::OP_SEC_READ);
        cmd_len <= len;
        @(posedge i_clk);
        cmd_valid <= 1'b0;
        @(negedge i_clk);
        while (done !== 1'b1)
            @(negedge i_clk);
    endtask
    // a refused read leaves the line released, so the host sees all ones
    task automatic rd(input logic [23:0] addr, input logic [10:0] len, input logic hit);
        rx_q.delete();
        cmd(sar_pkg::OP_SEC_READ, addr, len);
        chk_n("read byte count", int'(len), rx_q.size());
        for (int i = 0; i < int'(len); i++)
            chk8("read byte", hit ? pat(addr[9:0] + 10'(i)) : 8'hff, rx_q[i]);
    endtask
    task automatic step(input logic b, input logic v);
        @(posedge i_clk);
        busy <= b;
        vol_we <= v;
        @(posedge i_clk);
        vol_we <= 1'b0;
        repeat (4) @(posedge i_clk);
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        // a true rising edge once every process waits, so the link-side async clears fire
        i_sys_rst <= 1'b1;
        repeat (5) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        for (int a = 0; a < 1024; a++)
        begin
            @(posedge i_clk);
            mem_we <= 1'b1;
            mem_addr <= 10'(a);
            mem_wdata <= pat(10'(a));
        end
        @(posedge i_clk);
        mem_we <= 1'b0;
        rd(24'h0003fe, 11'h004, 1'b1);
        rd(24'h000105, 11'h003, 1'b1);
        step(1'b1, 1'b0);
        chk8("busy flag", 8'h01, {7'h00, status1[0]});
        rd(24'h000010, 11'h002, 1'b0);
        step(1'b0, 1'b1);
        chk8("status", 8'hfe, status1);
        cmd(sar_pkg::OP_RST, 24'h000000, 11'h000);
        // the deselect takes a few system clocks to reach the reset logic
        repeat (8) @(posedge i_clk);
        chk_n("abort count", 0, n_abort);
        cmd(sar_pkg::OP_RST_ARM, 24'h000000, 11'h000);
        rx_q.delete();
        cmd(sar_pkg::OP_RD_STATUS, 24'h000000, 11'h001);
        chk8("status read", 8'h02, rx_q[0]);
        cmd(sar_pkg::OP_RST, 24'h000000, 11'h000);
        repeat (8) @(posedge i_clk);
        chk_n("abort count", 0, n_abort);
        chk8("read parameter", 8'h5a, rparam);
        // reset while busy: the device must still abort
        step(1'b1, 1'b0);
        cmd(sar_pkg::OP_RST_ARM, 24'h000000, 11'h000);
        cmd(sar_pkg::OP_RST, 24'h000000, 11'h000);
        step(1'b0, 1'b0);
        chk_n("abort count", 1, n_abort);
        chk8("status", 8'h00, status1 & 8'hfe);
        chk8("read parameter", 8'h00, rparam);
        chk8("mode", 8'h00, cmode);
        chk8("wrap", 8'h00, {5'h00, wrap});
        while (rst_busy === 1'b1)
            @(negedge i_clk);
        chk_n("reset cycles", int'(sar_pkg::RST_CYC), n_rbusy);
        rd(24'h0003ff, 11'h002, 1'b1);
        test_done();
    end
endmodule // sar_test

// *** verilog/sar_dev.sv ***
// device end: secure-area read, status read and two-step soft reset
`timescale 1ns/1ns
module sar_dev (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    sar_link_if.dev link,
    input wire logic i_busy,
    input wire logic i_mem_we,
    input wire logic [9:0] i_mem_addr,
    input wire logic [7:0] i_mem_wdata,
    input wire logic i_vol_we,
    input wire logic [7:0] i_vol_status,
    input wire logic i_vol_write_enable_latch,
    input wire logic [7:0] i_vol_param,
    input wire logic [7:0] i_vol_mode,
    input wire logic [2:0] i_vol_wrap,
    output logic [7:0] o_status1,
    output logic [7:0] o_read_param,
    output logic [7:0] o_cont_mode,
    output logic [2:0] o_wrap,
    output logic o_abort,
    output logic o_rst_busy
);
    // ------------------------------------------------------------
    // link domain: frame decode on rising edges
    // ------------------------------------------------------------
    logic frame_rst;
    logic [5:0] cnt_q;
    logic [22:0] sh_q;
    logic is_sec_q;
    logic is_stat_q;
    logic [9:0] addr_q;
    logic [7:0] cmd_q;
    logic cmd_tog_q;
    logic [2:0] lsy1_q;
    logic [2:0] lsy2_q;
    logic [7:0] op_now;
    logic [23:0] addr_now;
    logic write_enable_latch_q;
    logic rst_busy_q;
    logic busy_any_q;

    // chip select high is the frame's own end: no sck edge is needed to tidy up
    assign frame_rst = link.cs_n | i_sys_rst;
    assign op_now = {sh_q[6:0], link.si};
    assign addr_now = {sh_q[22:0], link.si};

    always_ff @(posedge link.sck or posedge frame_rst)
    begin
        if (frame_rst)
        begin
            cnt_q <= 6'h00;
            sh_q <= 23'h000000;
            is_sec_q <= 1'b0;
            is_stat_q <= 1'b0;
            addr_q <= 10'h000;
        end
        else
        begin
            sh_q <= addr_now[22:0];
            if (cnt_q != sar_pkg::CNT_DATA)
            begin
                cnt_q <= cnt_q + 6'h01;
            end
            if (cnt_q == sar_pkg::CNT_OP_LAST)
            begin
                // lsy2_q: 0 any busy, 1 reset in progress
                is_sec_q <= (op_now == sar_pkg::OP_SEC_READ) && !lsy2_q[0];
                is_stat_q <= (op_now == sar_pkg::OP_RD_STATUS) && !lsy2_q[1];
            end
            if (cnt_q == sar_pkg::CNT_ADDR_LAST)
            begin
                addr_q <= addr_now[9:0];
            end
        end
    end

    // opcode handed to the system clock by toggle; survives deselect
    always_ff @(posedge link.sck or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            cmd_q <= 8'h00;
            cmd_tog_q <= 1'b0;
        end
        else if (cnt_q == sar_pkg::CNT_OP_LAST)
        begin
            cmd_q <= op_now;
            cmd_tog_q <= ~cmd_tog_q;
        end
    end

    // status levels into the link domain; settle within the opcode bits
    always_ff @(posedge link.sck or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            lsy1_q <= 3'h0;
            lsy2_q <= 3'h0;
        end
        else
        begin
            lsy1_q <= {write_enable_latch_q, rst_busy_q, busy_any_q};
            lsy2_q <= lsy1_q;
        end
    end

    // ------------------------------------------------------------
    // link domain: data out on falling edges
    // ------------------------------------------------------------
    logic [2:0] obit_q;
    logic [7:0] osh_q;
    logic so_q;
    logic oe_q;
    logic pref_q;
    logic [9:0] raddr_q;
    logic data_go;
    logic req_fire;
    logic [9:0] req_addr_d;
    logic [9:0] req_addr_q;
    logic req_tog_q;
    logic [7:0] out_byte;
    logic [7:0] rdata_q;

    assign data_go = (is_sec_q && (cnt_q == sar_pkg::CNT_DATA))
        || (is_stat_q && (cnt_q >= 6'(sar_pkg::OP_BITS)));
    assign out_byte = is_stat_q ? {6'h00, lsy2_q[2], lsy2_q[0]} : rdata_q;
    // first fetch once the address is in, then one ahead of every byte sent
    assign req_fire = is_sec_q && (((cnt_q == sar_pkg::CNT_ADDR_DONE) && !pref_q)
        || (data_go && (obit_q == 3'h0)));
    // ten-bit sum wraps 3ffh back to 000h by itself
    assign req_addr_d = pref_q ? raddr_q + 10'h001 : addr_q;

    always_ff @(negedge link.sck or posedge frame_rst)
    begin
        if (frame_rst)
        begin
            obit_q <= 3'h0;
            osh_q <= 8'h00;
            so_q <= 1'b0;
            oe_q <= 1'b0;
            pref_q <= 1'b0;
            raddr_q <= 10'h000;
        end
        else
        begin
            if (req_fire)
            begin
                pref_q <= 1'b1;
                raddr_q <= req_addr_d;
            end
            if (data_go)
            begin
                oe_q <= 1'b1;
                obit_q <= obit_q + 3'h1;
                if (obit_q == 3'h0)
                begin
                    so_q <= out_byte[7];
                    osh_q <= {out_byte[6:0], 1'b0};
                end
                else
                begin
                    so_q <= osh_q[7];
                    osh_q <= {osh_q[6:0], 1'b0};
                end
            end
        end
    end

    always_ff @(negedge link.sck or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            req_addr_q <= 10'h000;
            req_tog_q <= 1'b0;
        end
        else if (req_fire)
        begin
            req_addr_q <= req_addr_d;
            req_tog_q <= ~req_tog_q;
        end
    end

    assign link.so = so_q;
    assign link.so_oe = oe_q;

    // ------------------------------------------------------------
    // system domain: synchronisers and byte fetch
    // ------------------------------------------------------------
    logic [2:0] csy_q;
    logic [2:0] tsy_q;
    logic [2:0] rsy_q;
    logic cs_rise;
    logic new_cmd;
    logic [7:0] mem [0:sar_pkg::SEC_BYTES-1];

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            csy_q <= 3'h7;
            tsy_q <= 3'h0;
            rsy_q <= 3'h0;
        end
        else
        begin
            csy_q <= {csy_q[1:0], link.cs_n};
            tsy_q <= {tsy_q[1:0], cmd_tog_q};
            rsy_q <= {rsy_q[1:0], req_tog_q};
        end
    end

    assign cs_rise = csy_q[1] && !csy_q[2];
    assign new_cmd = tsy_q[1] ^ tsy_q[2];

    // address word stays put from its toggle until the next, a byte time later
    always_ff @(posedge i_clk)
    begin
        if (i_mem_we)
        begin
            mem[i_mem_addr] <= i_mem_wdata;
        end
        if (rsy_q[1] ^ rsy_q[2])
        begin
            rdata_q <= mem[req_addr_q];
        end
    end

    // ------------------------------------------------------------
    // system domain: reset sequence
    // ------------------------------------------------------------
    logic pend_q;
    logic arm_q;
    logic [11:0] rst_cnt_q;
    logic abort_q;
    logic cmd_done;
    logic rst_go;

    // an opcode whose toggle lands with the deselect still counts
    assign cmd_done = cs_rise && (pend_q || new_cmd) && !rst_busy_q;
    assign rst_go = cmd_done && arm_q && (cmd_q == sar_pkg::OP_RST);

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            pend_q <= 1'b0;
            arm_q <= 1'b0;
        end
        else
        begin
            if (cs_rise)
            begin
                pend_q <= 1'b0;
            end
            else if (new_cmd)
            begin
                pend_q <= 1'b1;
            end
            if (cmd_done)
            begin
                arm_q <= (cmd_q == sar_pkg::OP_RST_ARM);
            end
        end
    end

    // busy for the whole reset; cycle count is the longest time, rounded down
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            rst_busy_q <= 1'b0;
            rst_cnt_q <= 12'h000;
            abort_q <= 1'b0;
        end
        else
        begin
            abort_q <= rst_go;
            if (rst_go)
            begin
                rst_busy_q <= 1'b1;
                rst_cnt_q <= sar_pkg::RST_CYC - 12'h001;
            end
            else if (rst_cnt_q != 12'h000)
            begin
                rst_cnt_q <= rst_cnt_q - 12'h001;
            end
            else
            begin
                rst_busy_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // system domain: volatile settings and status
    // ------------------------------------------------------------
    logic [7:0] vol_status_q;

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst || rst_go)
        begin
            vol_status_q <= sar_pkg::VOL_STATUS_RST;
            write_enable_latch_q <= 1'b0;
            o_read_param <= 8'h00;
            o_cont_mode <= 8'h00;
            o_wrap <= 3'h0;
        end
        else if (i_vol_we)
        begin
            vol_status_q <= i_vol_status;
            write_enable_latch_q <= i_vol_write_enable_latch;
            o_read_param <= i_vol_param;
            o_cont_mode <= i_vol_mode;
            o_wrap <= i_vol_wrap;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            busy_any_q <= 1'b0;
            o_status1 <= 8'h00;
        end
        else
        begin
            busy_any_q <= i_busy || rst_busy_q;
            o_status1 <= vol_status_q;
            o_status1[sar_pkg::STAT_WRITE_ENABLE_LATCH_BIT] <= write_enable_latch_q;
            o_status1[sar_pkg::STAT_BUSY_BIT] <= busy_any_q;
        end
    end

    assign o_abort = abort_q;
    assign o_rst_busy = rst_busy_q;
endmodule // sar_dev

// *** verilog/sar_host.sv ***
// host end: frames commands, makes the serial clock, collects read bytes
`timescale 1ns/1ns
module sar_host (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    sar_link_if.host link,
    input wire logic i_cmd_valid,
    input wire logic [7:0] i_cmd_op,
    input wire logic [23:0] i_cmd_addr,
    input wire logic i_cmd_addr_en,
    input wire logic i_cmd_dummy_en,
    input wire logic [10:0] i_cmd_rd_len,
    output logic o_cmd_ready,
    output logic o_rd_valid,
    output logic [7:0] o_rd_data,
    output logic o_done
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [2:0] {H_IDLE, H_RUN, H_END, H_GAP, H_HOLD} sar_hst_e;
    sar_hst_e st_q;
    logic [3:0] div_q;
    logic tick;
    logic sck_q;
    logic cs_n_q;
    logic si_q;
    logic [38:0] tx_q;
    logic [14:0] nbits_q;
    logic [5:0] hdr_q;
    logic [2:0] rbit_q;
    logic [7:0] rx_q;
    logic [7:0] op_q;
    logic [11:0] wait_q;
    logic [1:0] sosy_q;
    logic [5:0] hdr_d;

    assign tick = (div_q == sar_pkg::SCK_HALF - 4'h1);
    assign hdr_d = 6'(sar_pkg::OP_BITS) + (i_cmd_addr_en ? 6'(sar_pkg::ADDR_BITS) : 6'h00)
        + (i_cmd_dummy_en ? 6'(sar_pkg::DUMMY_BITS) : 6'h00);

    // data-out changes on the far clock's edges: sync before sampling
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            sosy_q <= 2'h3;
        end
        else
        begin
            sosy_q <= {sosy_q[0], link.so_line};
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst || st_q == H_IDLE || tick)
        begin
            div_q <= 4'h0;
        end
        else
        begin
            div_q <= div_q + 4'h1;
        end
    end

    // ------------------------------------------------------------
    // frame sequencer
    // ------------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            st_q <= H_IDLE;
            sck_q <= 1'b0;
            cs_n_q <= 1'b1;
            si_q <= 1'b0;
            tx_q <= 39'h0;
            nbits_q <= 15'h0;
            hdr_q <= 6'h00;
            rbit_q <= 3'h0;
            rx_q <= 8'h00;
            op_q <= 8'h00;
            wait_q <= 12'h000;
            o_cmd_ready <= 1'b0;
            o_rd_valid <= 1'b0;
            o_rd_data <= 8'h00;
            o_done <= 1'b0;
        end
        else
        begin
            o_rd_valid <= 1'b0;
            o_done <= 1'b0;
            unique case (st_q)
                H_IDLE:
                begin
                    o_cmd_ready <= 1'b1;
                    if (i_cmd_valid && o_cmd_ready)
                    begin
                        // opcode, address, dummies, then data, one frame
                        cs_n_q <= 1'b0;
                        si_q <= i_cmd_op[7];
                        tx_q <= {i_cmd_op[6:0], i_cmd_addr_en ? i_cmd_addr : 24'h0, 8'h00};
                        hdr_q <= hdr_d;
                        nbits_q <= 15'(hdr_d) + {1'b0, i_cmd_rd_len, 3'h0};
                        rbit_q <= 3'h0;
                        op_q <= i_cmd_op;
                        o_cmd_ready <= 1'b0;
                        st_q <= H_RUN;
                    end
                end
                H_RUN:
                begin
                    if (tick && !sck_q)
                    begin
                        sck_q <= 1'b1;
                        nbits_q <= nbits_q - 15'h1;
                        if (hdr_q != 6'h00)
                        begin
                            hdr_q <= hdr_q - 6'h01;
                        end
                        else
                        begin
                            rx_q <= {rx_q[6:0], sosy_q[1]};
                            rbit_q <= rbit_q + 3'h1;
                            if (rbit_q == 3'h7)
                            begin
                                o_rd_valid <= 1'b1;
                                o_rd_data <= {rx_q[6:0], sosy_q[1]};
                            end
                        end
                    end
                    else if (tick)
                    begin
                        sck_q <= 1'b0;
                        si_q <= tx_q[38];
                        tx_q <= {tx_q[37:0], 1'b0};
                        if (nbits_q == 15'h0)
                        begin
                            st_q <= H_END;
                        end
                    end
                end
                H_END:
                begin
                    if (tick)
                    begin
                        cs_n_q <= 1'b1;
                        o_done <= 1'b1;
                        st_q <= H_GAP;
                    end
                end
                H_GAP:
                begin
                    if (tick)
                    begin
                        wait_q <= sar_pkg::RST_CYC;
                        // a reset opcode may have been accepted: keep quiet throughout
                        st_q <= (op_q == sar_pkg::OP_RST) ? H_HOLD : H_IDLE;
                    end
                end
                H_HOLD:
                begin
                    wait_q <= wait_q - 12'h001;
                    if (wait_q == 12'h001)
                    begin
                        st_q <= H_IDLE;
                    end
                end
            endcase
        end
    end

    assign link.cs_n = cs_n_q;
    assign link.sck = sck_q;
    assign link.si = si_q;
endmodule // sar_host

// *** verilog/sar_link_if.sv ***
// serial link between the flash command logic and its host controller
`timescale 1ns/1ns
interface sar_link_if;
    logic cs_n;
    logic sck;
    logic si;
    logic so;
    logic so_oe;
    logic so_line;
    // undriven data-out line idles high, as a pull-up would leave it
    assign so_line = so_oe ? so : 1'b1;
    modport dev (input cs_n, input sck, input si, output so, output so_oe);
    modport host (output cs_n, output sck, output si, input so_line);
endinterface

// *** verilog/sar_pkg.sv ***
// shared constants for the secure-area read and soft reset link
package sar_pkg;
    // ------------------------------------------------------------
    // opcodes
    // ------------------------------------------------------------
    localparam logic [7:0] OP_SEC_READ = 8'h48;
    localparam logic [7:0] OP_RD_STATUS = 8'h05;
    localparam logic [7:0] OP_RST_ARM = 8'h66;
    localparam logic [7:0] OP_RST = 8'h99;
    // ------------------------------------------------------------
    // frame layout, counted in rising serial clock edges
    // ------------------------------------------------------------
    localparam int OP_BITS = 8;
    localparam int ADDR_BITS = 24;
    localparam int DUMMY_BITS = 8;
    localparam logic [5:0] CNT_OP_LAST = 6'h07;
    localparam logic [5:0] CNT_ADDR_LAST = 6'h1f;
    localparam logic [5:0] CNT_ADDR_DONE = 6'h20;
    localparam logic [5:0] CNT_DATA = 6'h28;
    localparam int SEC_AW = 10;
    localparam int SEC_BYTES = 1024;
    // ------------------------------------------------------------
    // status byte fields
    // ------------------------------------------------------------
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_WRITE_ENABLE_LATCH_BIT = 1;
    localparam logic [7:0] VOL_STATUS_RST = 8'h00;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    localparam int T_RST_NS = 30000;
    // longest time, so rounds down
    localparam logic [11:0] RST_CYC = 12'(T_RST_NS / CLK_PERIOD_NS);
    localparam logic [3:0] SCK_HALF = 4'h8;
endpackage
